/* File: gas_sensor_regs.v */
// Host-visible register slice of the gas sensor with command handling.
`timescale 1ns/1ps
`include "gas_sensor_defines.vh"

// Notes on behaviour
// [RULE1] Version query puts major, minor, release in readback bytes 4, 5, 6.
// [RULE2] Version placed sets readback-ready; alert only if so configured.
// [RULE3] Clear-readback command zeroes every readback byte.
// [RULE4] Temperature input at 0x13; low byte first; commit on upper byte.
// [RULE5] Host encodes temperature as kelvin times 64, unsigned 16 bits.
// [RULE6] Humidity input at 0x15; low byte first; commit on upper byte.
// [RULE7] Host encodes humidity as percent times 512, unsigned 16 bits.
// [RULE8] Status bit 7 is high while an operating mode runs; resets zero.
// [RULE9] Status bit 6 flags a detected error such as an invalid mode.
// [RULE10] Status bits 3:2 report validity: normal, warm-up, unused, invalid.
// [RULE11] Status bit 1 marks new results; cleared by first result read.
// [RULE12] Bit 0 flags new readback bytes; the first readback read clears it.
// [RULE13] Air index in bits 2:0, values 1 to 5, reset 1, upper bits zero.
// [RULE14] VOC-equivalent result in ppb is a two-byte read-only at 0x22.
// [RULE15] Commands accepted any time, executed only in idle mode.
// [RULE16] Alert on readback-ready needs trigger bit 3 and master bit 0.
// [RULE17] Multi-byte registers are little endian, low byte at low address.
// [RULE18] A cleared causing flag drops the alert unless another cause pends.
module gas_sensor_regs #(
  parameter [7:0] FW_MAJOR = 8'h01,
  parameter [7:0] FW_MINOR = 8'h00,
  parameter [7:0] FW_RELEASE = 8'h00
) (
  input wire clock_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire result_update_i,
  input wire [2:0] air_index_i,
  input wire [15:0] voc_ppb_i,
  input wire [1:0] validity_i,
  input wire mode_fault_i,
  output reg [15:0] temp_comp_o,
  output reg temp_comp_update_o,
  output reg [15:0] hum_comp_o,
  output reg hum_comp_update_o,
  output reg [7:0] mode_select_o,
  output wire host_alert_pin_o,
  output wire host_alert_pin_oe_o
);

  // Command sequencer states, one-hot.
  localparam [4:0] S_WAIT = 5'h01;
  localparam [4:0] S_MAJOR = 5'h02;
  localparam [4:0] S_MINOR = 5'h04;
  localparam [4:0] S_RELEASE = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  // True for a result register address.
  function is_result;
    input [7:0] a;
    begin
      is_result = (a >= `ADDR_AIR_INDEX) && (a <= `ADDR_RESULT_LAST);
    end
  endfunction

  // True for a general-purpose readback address.
  function is_readback;
    input [7:0] a;
    begin
      is_readback = (a >= `ADDR_READBACK_BASE) &&
                    (a <= `ADDR_READBACK_LAST);
    end
  endfunction

  // True for a legal operating mode code.
  function mode_legal;
    input [7:0] m;
    begin
      mode_legal = (m <= `MODE_ULTRA_LOW) || (m == `MODE_RESET);
    end
  endfunction

  reg [7:0] mode_reg;
  reg [7:0] alert_cfg_reg;
  reg [7:0] command_reg;
  reg cmd_pending_reg;
  reg [7:0] temp_lsb_reg;
  reg [7:0] hum_lsb_reg;
  reg error_reg;
  reg result_ready_reg;
  reg readback_ready_reg;
  reg [2:0] air_index_reg;
  reg [15:0] voc_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [7:0] rd_local_reg;
  reg rd_from_mem_reg;
  reg rd_stage_reg;
  reg mem_wr_en;
  reg [2:0] mem_wr_idx;
  reg [7:0] mem_wr_data;
  reg mem_clear;
  reg alert;
  reg [7:0] status_byte;
  wire [7:0] mem_rd_data;
  wire wr_hit;
  wire rd_hit;
  wire in_idle;
  wire running;

  assign wr_hit = reg_wr_i;
  assign rd_hit = reg_rd_i;
  assign in_idle = (mode_reg == `MODE_IDLE);
  // Any of standard, low power or ultra low power counts as running.
  assign running = (mode_reg >= `MODE_STANDARD) &&
                   (mode_reg <= `MODE_ULTRA_LOW); // [RULE8]

  // Mode select and alert configuration written by the host.
  always @(posedge clock_i) begin
    if (srst_i) begin
      mode_reg <= `RST_MODE;
      alert_cfg_reg <= `RST_BYTE;
    end else if (wr_hit) begin
      if (reg_addr_i == `ADDR_MODE_SELECT) begin
        mode_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `ADDR_ALERT_CFG) begin
        alert_cfg_reg <= reg_wdata_i & 8'h6B;
      end
    end
  end

  // Command is stored at once but only acted on in idle mode.
  always @(posedge clock_i) begin
    if (srst_i) begin
      command_reg <= `CMD_NOP;
      cmd_pending_reg <= 1'b0;
    end else if (wr_hit && (reg_addr_i == `ADDR_COMMAND)) begin
      command_reg <= reg_wdata_i; // [RULE15]
      cmd_pending_reg <= 1'b1;
    end else if (cmd_pending_reg && in_idle && (state_reg == S_WAIT)) begin
      cmd_pending_reg <= 1'b0; // [RULE15]
    end
  end

  // Compensation inputs: low byte held, commit when the upper byte lands.
  always @(posedge clock_i) begin
    if (srst_i) begin
      temp_lsb_reg <= `RST_BYTE;
      hum_lsb_reg <= `RST_BYTE;
      temp_comp_o <= `RST_WORD;
      hum_comp_o <= `RST_WORD;
      temp_comp_update_o <= 1'b0;
      hum_comp_update_o <= 1'b0;
    end else begin
      temp_comp_update_o <= 1'b0;
      hum_comp_update_o <= 1'b0;
      if (wr_hit && (reg_addr_i == `ADDR_TEMP_LSB)) begin
        temp_lsb_reg <= reg_wdata_i;
      end
      if (wr_hit && (reg_addr_i == `ADDR_TEMP_MSB)) begin
        temp_comp_o <= {reg_wdata_i, temp_lsb_reg}; // [RULE4] [RULE17]
        temp_comp_update_o <= 1'b1; // [RULE4]
      end
      if (wr_hit && (reg_addr_i == `ADDR_HUM_LSB)) begin
        hum_lsb_reg <= reg_wdata_i;
      end
      if (wr_hit && (reg_addr_i == `ADDR_HUM_MSB)) begin
        hum_comp_o <= {reg_wdata_i, hum_lsb_reg}; // [RULE6] [RULE17]
        hum_comp_update_o <= 1'b1; // [RULE6]
      end
    end
  end

  // Mode select seen by the sensing engine.
  always @* begin
    mode_select_o = mode_reg;
  end

  // Error latches on an illegal mode or engine fault; a legal mode clears it.
  always @(posedge clock_i) begin
    if (srst_i) begin
      error_reg <= 1'b0;
    end else if (mode_fault_i) begin
      error_reg <= 1'b1; // [RULE9]
    end else if (wr_hit && (reg_addr_i == `ADDR_MODE_SELECT)) begin
      error_reg <= ~mode_legal(reg_wdata_i); // [RULE9]
    end
  end

  // Results captured from the engine; a new set raises result-ready.
  always @(posedge clock_i) begin
    if (srst_i) begin
      air_index_reg <= `RST_AIR_INDEX; // [RULE13]
      voc_reg <= `RST_WORD;
      result_ready_reg <= 1'b0;
    end else begin
      if (result_update_i) begin
        air_index_reg <= air_index_i; // [RULE13]
        voc_reg <= voc_ppb_i; // [RULE14]
      end
      // Set beats a clear arriving in the same cycle.
      if (result_update_i) begin
        result_ready_reg <= 1'b1; // [RULE11]
      end else if (rd_hit && is_result(reg_addr_i)) begin
        result_ready_reg <= 1'b0; // [RULE11]
      end
    end
  end

  // Sequencer that writes the version bytes or clears the readback store.
  always @* begin
    state_next = state_reg;
    mem_wr_en = 1'b0;
    mem_wr_idx = `RB_IDX_MAJOR;
    mem_wr_data = FW_MAJOR;
    mem_clear = 1'b0;
    case (state_reg)
      S_WAIT: begin
        if (cmd_pending_reg && in_idle) begin
          if (command_reg == `CMD_FW_VERSION) begin
            state_next = S_MAJOR;
          end else if (command_reg == `CMD_CLEAR_READBACK) begin
            mem_clear = 1'b1; // [RULE3]
          end
        end
      end
      S_MAJOR: begin
        mem_wr_en = 1'b1;
        mem_wr_idx = `RB_IDX_MAJOR; // [RULE1]
        mem_wr_data = FW_MAJOR;
        state_next = S_MINOR;
      end
      S_MINOR: begin
        mem_wr_en = 1'b1;
        mem_wr_idx = `RB_IDX_MINOR; // [RULE1]
        mem_wr_data = FW_MINOR;
        state_next = S_RELEASE;
      end
      S_RELEASE: begin
        mem_wr_en = 1'b1;
        mem_wr_idx = `RB_IDX_RELEASE; // [RULE1]
        mem_wr_data = FW_RELEASE;
        state_next = S_DONE;
      end
      S_DONE: begin
        state_next = S_WAIT;
      end
      default: begin
        state_next = S_WAIT;
      end
    endcase
  end

  // Sequencer state register.
  always @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= S_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Readback-ready rises once all version bytes are stored.
  always @(posedge clock_i) begin
    if (srst_i) begin
      readback_ready_reg <= 1'b0;
    end else if (state_reg == S_DONE) begin
      readback_ready_reg <= 1'b1; // [RULE2]
    end else if (rd_hit && is_readback(reg_addr_i)) begin
      readback_ready_reg <= 1'b0; // [RULE12]
    end
  end

  // Status byte assembled from live state; reserved bits read zero.
  always @* begin
    status_byte = 8'h00;
    status_byte[`ST_RUNNING] = running; // [RULE8]
    status_byte[`ST_ERROR] = error_reg; // [RULE9]
    status_byte[`ST_VALID_HI:`ST_VALID_LO] = validity_i; // [RULE10]
    status_byte[`ST_RESULT_READY] = result_ready_reg; // [RULE11]
    status_byte[`ST_READBACK_READY] = readback_ready_reg; // [RULE12]
  end

  // First read stage: pick the local byte or mark a readback access.
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_local_reg <= `RST_BYTE;
      rd_from_mem_reg <= 1'b0;
      rd_stage_reg <= 1'b0;
    end else begin
      rd_stage_reg <= rd_hit;
      rd_from_mem_reg <= is_readback(reg_addr_i);
      case (reg_addr_i)
        `ADDR_MODE_SELECT: rd_local_reg <= mode_reg;
        `ADDR_ALERT_CFG: rd_local_reg <= alert_cfg_reg;
        `ADDR_COMMAND: rd_local_reg <= command_reg;
        `ADDR_TEMP_LSB: rd_local_reg <= temp_lsb_reg;
        `ADDR_TEMP_MSB: rd_local_reg <= temp_comp_o[15:8];
        `ADDR_HUM_LSB: rd_local_reg <= hum_lsb_reg;
        `ADDR_HUM_MSB: rd_local_reg <= hum_comp_o[15:8];
        `ADDR_STATUS: rd_local_reg <= status_byte;
        `ADDR_AIR_INDEX: rd_local_reg <= {5'h00, air_index_reg}; // [RULE13]
        `ADDR_VOC_LSB: rd_local_reg <= voc_reg[7:0]; // [RULE14] [RULE17]
        `ADDR_VOC_MSB: rd_local_reg <= voc_reg[15:8]; // [RULE14]
        default: rd_local_reg <= 8'h00;
      endcase
    end
  end

  // Second read stage: final data and its valid pulse.
  always @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= `RST_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= rd_stage_reg;
      reg_rdata_o <= rd_from_mem_reg ? mem_rd_data : rd_local_reg;
    end
  end

  // Alert follows the enabled pending flags and drops when they clear.
  always @* begin
    alert = alert_cfg_reg[`CFG_MASTER_EN] &
            ((alert_cfg_reg[`CFG_ON_READBACK] & readback_ready_reg) |
             (alert_cfg_reg[`CFG_ON_RESULT] & result_ready_reg));
    // [RULE2] [RULE16] [RULE18]
  end

  readback_mem #(
    .DEPTH(8),
    .AW(3)
  ) u_readback (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .clear_i(mem_clear),
    .wr_en_i(mem_wr_en),
    .wr_idx_i(mem_wr_idx),
    .wr_data_i(mem_wr_data),
    .rd_idx_i(reg_addr_i[2:0]),
    .rd_data_o(mem_rd_data)
  );

  alert_pin_driver u_alert (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .alert_i(alert),
    .active_high_i(alert_cfg_reg[`CFG_POLARITY]),
    .push_pull_i(alert_cfg_reg[`CFG_PUSH_PULL]),
    .host_alert_pin_o(host_alert_pin_o),
    .host_alert_pin_oe_o(host_alert_pin_oe_o)
  );

endmodule

/* File: gas_sensor_defines.vh */
// Register map, field positions, reset values and command codes.
`ifndef GAS_SENSOR_DEFINES_VH
`define GAS_SENSOR_DEFINES_VH

// Register offsets on the serial register port.
`define ADDR_MODE_SELECT 8'h10
`define ADDR_ALERT_CFG 8'h11
`define ADDR_COMMAND 8'h12
`define ADDR_TEMP_LSB 8'h13
`define ADDR_TEMP_MSB 8'h14
`define ADDR_HUM_LSB 8'h15
`define ADDR_HUM_MSB 8'h16
`define ADDR_STATUS 8'h20
`define ADDR_AIR_INDEX 8'h21
`define ADDR_VOC_LSB 8'h22
`define ADDR_VOC_MSB 8'h23
`define ADDR_RESULT_LAST 8'h37
`define ADDR_READBACK_BASE 8'h48
`define ADDR_READBACK_LAST 8'h4F

// Readback byte indices for the firmware version.
`define RB_IDX_MAJOR 3'h4
`define RB_IDX_MINOR 3'h5
`define RB_IDX_RELEASE 3'h6

// Operating modes.
`define MODE_DEEP_SLEEP 8'h00
`define MODE_IDLE 8'h01
`define MODE_STANDARD 8'h02
`define MODE_LOW_POWER 8'h03
`define MODE_ULTRA_LOW 8'h04
`define MODE_RESET 8'hF0

// Command codes.
`define CMD_NOP 8'h00
`define CMD_FW_VERSION 8'h0E
`define CMD_CLEAR_READBACK 8'hCC

// Status bit positions.
`define ST_RUNNING 7
`define ST_ERROR 6
`define ST_VALID_HI 3
`define ST_VALID_LO 2
`define ST_RESULT_READY 1
`define ST_READBACK_READY 0

// Alert configuration bit positions.
`define CFG_POLARITY 6
`define CFG_PUSH_PULL 5
`define CFG_ON_READBACK 3
`define CFG_ON_RESULT 1
`define CFG_MASTER_EN 0

// Reset values.
`define RST_MODE 8'h01
`define RST_AIR_INDEX 3'h1
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00

`endif

/* File: readback_mem.v */
// Eight general-purpose readback bytes with registered read data.
`timescale 1ns/1ps
module readback_mem #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire srst_i,
  input wire clear_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_idx_i,
  input wire [7:0] wr_data_i,
  input wire [AW-1:0] rd_idx_i,
  output reg [7:0] rd_data_o
);

  reg [7:0] mem_reg [0:DEPTH-1];
  integer i;

  // Clear wipes every byte at once; a write in the same cycle is dropped.
  always @(posedge clock_i) begin
    if (srst_i || clear_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (wr_en_i) begin
      mem_reg[wr_idx_i] <= wr_data_i;
    end
  end

  // Read data always comes out of a register.
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_reg[rd_idx_i];
    end
  end

endmodule

/* File: alert_pin_driver.v */
// Drives the host alert pin with configurable polarity and drive style.
`timescale 1ns/1ps
module alert_pin_driver (
  input wire clock_i,
  input wire srst_i,
  input wire alert_i,
  input wire active_high_i,
  input wire push_pull_i,
  output reg host_alert_pin_o,
  output reg host_alert_pin_oe_o
);

  reg level;

  // Electrical level wanted on the pin for the current alert state.
  always @* begin
    level = alert_i ? active_high_i : ~active_high_i;
  end

  // Open drain only pulls low; push-pull always drives.
  always @(posedge clock_i) begin
    if (srst_i) begin
      host_alert_pin_o <= 1'b0;
      host_alert_pin_oe_o <= 1'b0;
    end else begin
      host_alert_pin_o <= level;
      host_alert_pin_oe_o <= push_pull_i | ~level;
    end
  end

endmodule

/* File: gas_sensor_regs_monitor.sv */
// Concurrent checks on the ports of the gas sensor register slice.
`timescale 1ns/1ps
module gas_sensor_regs_monitor (
  input wire clock_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire [1:0] validity_i,
  input wire [15:0] temp_comp_o,
  input wire temp_comp_update_o,
  input wire [15:0] hum_comp_o,
  input wire hum_comp_update_o
);
  // All checks share the one clock and its synchronous reset.
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_rd_answer;
    reg_rd_i |-> ##2 reg_rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing two cycles after request");
  property p_rd_origin;
    reg_rvalid_o |-> $past(reg_rd_i, 2);
  endproperty
  a_rd_origin: assert property (p_rd_origin)
    else $error("read answer without a request");
  property p_temp_commit;
    reg_wr_i && reg_addr_i == 8'h14 |=>
      temp_comp_update_o && temp_comp_o[15:8] == $past(reg_wdata_i);
  endproperty
  a_temp_commit: assert property (p_temp_commit)
    else $error("temperature not committed on upper byte");
  property p_temp_cause;
    temp_comp_update_o |-> $past(reg_wr_i && reg_addr_i == 8'h14);
  endproperty
  a_temp_cause: assert property (p_temp_cause)
    else $error("temperature update without upper byte write");
  property p_temp_hold;
    reg_wr_i && reg_addr_i == 8'h13 |=> $stable(temp_comp_o);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("temperature changed on lower byte write");
  property p_hum_commit;
    reg_wr_i && reg_addr_i == 8'h16 |=>
      hum_comp_update_o && hum_comp_o[15:8] == $past(reg_wdata_i);
  endproperty
  a_hum_commit: assert property (p_hum_commit)
    else $error("humidity not committed on upper byte");
  property p_hum_cause;
    hum_comp_update_o |-> $past(reg_wr_i && reg_addr_i == 8'h16);
  endproperty
  a_hum_cause: assert property (p_hum_cause)
    else $error("humidity update without upper byte write");
  property p_air_reserved;
    reg_rd_i && reg_addr_i == 8'h21 |-> ##2 reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_air_reserved: assert property (p_air_reserved)
    else $error("air index upper bits not zero");
  property p_validity;
    reg_rd_i && reg_addr_i == 8'h20 ##1 $stable(validity_i)
      ##1 $stable(validity_i) |-> reg_rdata_o[3:2] == validity_i;
  endproperty
  a_validity: assert property (p_validity)
    else $error("status validity field wrong");
endmodule

bind gas_sensor_regs gas_sensor_regs_monitor mon (
  .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .validity_i(validity_i), .temp_comp_o(temp_comp_o),
  .temp_comp_update_o(temp_comp_update_o), .hum_comp_o(hum_comp_o),
  .hum_comp_update_o(hum_comp_update_o));

/* File: host_model.sv */
// Host processor model that drives the byte-wide register port.
`timescale 1ns/1ps
module host_model (
  input wire clock_i,
  input wire [7:0] rdata_i,
  input wire rvalid_i,
  output reg [7:0] addr_o,
  output reg wr_o,
  output reg [7:0] wdata_o,
  output reg rd_o
);
  // The port is quiet at time zero.
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end

  // One write pulse; released lines show the inverse of the last value.
  task wr_byte(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clock_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
    end
  endtask

  // Two-byte value, lower byte first so the upper byte commits it.
  task wr_word(input [7:0] a, input [15:0] w);
    begin
      wr_byte(a, w[7:0]);
      wr_byte(a + 8'h01, w[15:8]);
    end
  endtask

  // Commands may be written in any mode.
  task cmd(input [7:0] c);
    begin
      wr_byte(8'h12, c);
    end
  endtask

  // One read pulse, then a bounded wait for the answer.
  task rd_byte(input [7:0] a, output [7:0] d);
    integer n;
    begin
      @(negedge clock_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clock_i);
      rd_o = 1'b0;
      addr_o = ~a;
      n = 0;
      while (rvalid_i !== 1'b1 && n < 4) begin
        @(negedge clock_i);
        n = n + 1;
      end
      d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
    end
  endtask

  // Temperature code from hundredths of a degree: kelvin times 64.
  function [15:0] temp_code(input integer centi);
    temp_code = ((centi + 27315) * 64 + 50) / 100;
  endfunction

  // Humidity code from whole percent: percent times 512.
  function [15:0] hum_code(input integer pct);
    hum_code = pct * 512;
  endfunction
endmodule

/* File: testbench.sv */
// Self-checking testbench for the gas sensor register slice.
`timescale 1ns/1ps
module testbench;
  localparam [7:0] FW_MA = 8'h3A;
  localparam [7:0] FW_MI = 8'h5C;
  localparam [7:0] FW_RE = 8'h71;
  reg clock = 1'b0;
  reg srst = 1'b1;
  reg result_update = 1'b0;
  reg [2:0] air_index = 3'h1;
  reg [15:0] voc_ppb = 16'h0000;
  reg [1:0] validity = 2'h0;
  reg mode_fault = 1'b0;
  wire [7:0] addr, wdata, rdata, mode_sel;
  wire wr, rd, rvalid, t_upd, h_upd, pin, pin_oe;
  wire [15:0] temp_c, hum_c;
  integer miscompares = 0, checked = 0, cycles = 0, i, k;
  reg [7:0] d;
  reg [15:0] w;

  gas_sensor_regs #(.FW_MAJOR(FW_MA), .FW_MINOR(FW_MI), .FW_RELEASE(FW_RE))
    dut (.clock_i(clock), .srst_i(srst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .result_update_i(result_update),
    .air_index_i(air_index), .voc_ppb_i(voc_ppb), .validity_i(validity),
    .mode_fault_i(mode_fault), .temp_comp_o(temp_c),
    .temp_comp_update_o(t_upd), .hum_comp_o(hum_c),
    .hum_comp_update_o(h_upd), .mode_select_o(mode_sel),
    .host_alert_pin_o(pin), .host_alert_pin_oe_o(pin_oe));
  host_model host (.clock_i(clock), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

  // Free-running clock and a cycle ceiling against hangs.
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end

  // Expected status byte from its fields.
  function [7:0] st(input run, input err, input [1:0] v, input res, input rb);
    st = {run, err, 2'b00, v, res, rb};
  endfunction

  // Compares a seen value with the expected one and counts both.
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Reads one register and compares it.
  task rchk(input [7:0] a, input [7:0] e);
    begin
      host.rd_byte(a, d);
      check({8'h00, d}, {8'h00, e});
    end
  endtask

  // Prints the verdict and ends the run.
  task complete_run;
    begin
      if (miscompares == 0 && checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  // Main sequence of scenarios.
  initial begin
    i = $urandom(32'h64C9);
    repeat (4) @(negedge clock);
    srst = 1'b0;
    check({8'h00, mode_sel}, 16'h0001);
    rchk(8'h14, 8'h00);
    rchk(8'h21, 8'h01);
    rchk(8'h20, st(0, 0, 0, 0, 0));
    w = host.temp_code(2500);
    check(w, 16'h4A8A);
    host.wr_word(8'h13, w);
    @(negedge clock);
    check(temp_c, w);
    host.wr_byte(8'h13, 8'h55);
    check(temp_c, w);
    rchk(8'h13, 8'h55);
    rchk(8'h14, w[15:8]);
    check(host.hum_code(50), 16'h6400);
    for (i = 0; i < 3; i = i + 1) begin
      w = host.hum_code($urandom_range(5, 95));
      host.wr_word(8'h15, w);
      @(negedge clock);
      check(hum_c, w);
    end
    for (i = 0; i < 4; i = i + 1) begin
      air_index = $urandom_range(1, 5);
      voc_ppb = $urandom;
      validity = i[1:0];
      result_update = 1'b1;
      @(negedge clock);
      result_update = 1'b0;
      rchk(8'h20, st(0, 0, validity, 1, 0));
      rchk(8'h21, {5'h00, air_index});
      rchk(8'h22, voc_ppb[7:0]);
      rchk(8'h23, voc_ppb[15:8]);
      rchk(8'h20, st(0, 0, validity, 0, 0));
    end
    validity = 2'h0;
    // The last pass drives an active-low open-drain pin.
    for (i = 0; i < 4; i = i + 1) begin
      host.wr_byte(8'h11, (i == 0) ? 8'h69 : ((i == 1) ? 8'h61 :
        ((i == 2) ? 8'h68 : 8'h09)));
      host.cmd(8'h0E);
      repeat (12) @(negedge clock);
      check({15'h0000, pin}, {15'h0000, i == 0});
      check({15'h0000, pin_oe}, 16'h0001);
      rchk(8'h20, st(0, 0, 0, 0, 1));
      rchk(8'h4C, FW_MA);
      repeat (2) @(negedge clock);
      check({15'h0000, pin}, {15'h0000, i == 3});
      check({15'h0000, pin_oe}, {15'h0000, i != 3});
      rchk(8'h4D, FW_MI);
      rchk(8'h4E, FW_RE);
      rchk(8'h20, st(0, 0, 0, 0, 0));
      host.cmd(8'hCC);
      for (k = 0; k < 8; k = k + 1) begin
        rchk(8'h48 + k[7:0], 8'h00);
      end
    end
    // Result-ready drives an active-low open-drain alert until read.
    host.wr_byte(8'h11, 8'h03);
    result_update = 1'b1;
    @(negedge clock);
    result_update = 1'b0;
    repeat (2) @(negedge clock);
    check({15'h0000, pin}, 16'h0000);
    check({15'h0000, pin_oe}, 16'h0001);
    rchk(8'h21, {5'h00, air_index});
    check({15'h0000, pin}, 16'h0001);
    check({15'h0000, pin_oe}, 16'h0000);
    host.wr_byte(8'h10, 8'h02);
    check({8'h00, mode_sel}, 16'h0002);
    rchk(8'h20, st(1, 0, 0, 0, 0));
    host.cmd(8'h0E);
    repeat (12) @(negedge clock);
    rchk(8'h4C, 8'h00);
    host.wr_byte(8'h10, 8'h01);
    repeat (12) @(negedge clock);
    rchk(8'h20, st(0, 0, 0, 0, 1));
    rchk(8'h4C, FW_MA);
    host.wr_byte(8'h10, 8'h07);
    rchk(8'h20, st(0, 1, 0, 0, 0));
    host.wr_byte(8'h10, 8'h01);
    rchk(8'h20, st(0, 0, 0, 0, 0));
    mode_fault = 1'b1;
    @(negedge clock);
    mode_fault = 1'b0;
    rchk(8'h20, st(0, 1, 0, 0, 0));
    complete_run;
  end
endmodule
